/* core/spi_eeprom_core.sv */
// spi eeprom command, protection and write-cycle logic
`timescale 1ns/100ps
module spi_eeprom_core #(
  parameter int WC_CYCLES = eeprom_pkg::WC_CYCLES,
  parameter bit LEGACY_BUSY_ALL_ONES = 1'b0
) (
  input logic clk,
  input logic rstn,
  input logic ce,
  input logic sck,
  input logic csN,
  input logic si,
  input logic holdN,
  input logic wpN,
  output logic so,
  output logic soOeN,
  output eeprom_pkg::status_s statusOut
);
  import eeprom_pkg::*;

  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] pageBuf [0:PAGE_BYTES-1];

  // link side, serial clock domain
  logic frameRstN;
  phase_e phase_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] sendCnt_r;
  logic [7:0] sh_r;
  logic [7:0] shNext;
  logic [7:0] cmdL_r;
  logic [ADDR_W-1:0] addrL_r;
  logic [ADDR_W-1:0] addrNext;
  logic [PAGE_BYTES-1:0] mask_r;
  logic [PAGE_W-1:0] wrPtr_r;
  logic gotByte_r;
  logic [2:0] bitsL_r;
  logic [7:0] stByte_r;
  logic [7:0] txSh_r;
  logic [7:0] stL1_r;
  logic [7:0] stL2_r;
  logic busyL;
  logic bufWe;

  // core side, system clock domain
  logic csS1, csS2, csPrev, wpS1, wpS2, wpPrev;
  logic csRise, csFall, wpFall;
  logic wel_r, ppe_r, busy_r, isSt_r, awake_r, wpFell_r;
  logic [1:0] bp_r;
  logic [WC_W-1:0] wcCnt_r;
  logic [PAGE_W:0] cpIdx_r;
  logic [PAGE_W-1:0] cpLow;
  logic [ADDR_W-PAGE_W-1:0] page_r;
  logic [7:0] stNew_r;
  logic framed, okWren, okWrdi, okWrite, okWrsr, wpBlock;

  function automatic logic isProt(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    logic [ADDR_W:0] lo;
    lo = PROT_NONE;
    case (bp)
      2'b00: lo = PROT_NONE;
      2'b01: lo = PROT_QTR;
      2'b10: lo = PROT_HALF;
      default: lo = PROT_ALL;
    endcase
    return {1'b0, a} >= lo;
  endfunction

  function automatic phase_e opcPhase(input logic [7:0] op, input logic busy);
    phase_e p;
    p = PH_IGN;
    case (op)
      CMD_READ_STATUS: p = PH_SEND;
      CMD_READ, CMD_WRITE: p = busy ? PH_IGN : PH_ADDR;
      CMD_WRITE_ENABLE, CMD_WRITE_DISABLE, CMD_WRITE_STATUS: p = busy ? PH_IGN : PH_DATA;
      default: p = PH_IGN;
    endcase
    return p;
  endfunction

  // select high clears the frame state; the pin acts as the frame's own reset
  assign frameRstN = rstn & ~csN;
  assign shNext = {sh_r[6:0], si};
  assign addrNext = {addrL_r[ADDR_W-2:0], si};
  assign busyL = stL2_r[ST_RDY];
  assign bufWe = holdN && phase_r == PH_DATA && cmdL_r == CMD_WRITE && bitsL_r == 3'h7;

  always_ff @(posedge sck or negedge frameRstN) begin
    if (!frameRstN) begin
      phase_r <= PH_OPC;
      cnt_r <= '0;
      sendCnt_r <= '0;
    end else if (holdN) begin
      cnt_r <= cnt_r + 5'h01;
      case (phase_r)
        PH_OPC: begin
          if (cnt_r == OPC_LAST) begin
            cnt_r <= '0;
            phase_r <= opcPhase(shNext, busyL);
          end
        end
        PH_ADDR: begin
          if (cnt_r == ADDR_LAST) begin
            phase_r <= (cmdL_r == CMD_READ) ? PH_SEND : PH_DATA;
          end
        end
        PH_SEND: sendCnt_r <= sendCnt_r + 3'h1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      stL1_r <= '0;
      stL2_r <= '0;
    end else begin
      // status changes only at select rise or at the end of a write cycle, so a per-bit copy is coherent
      stL1_r <= statusOut;
      stL2_r <= stL1_r;
    end
  end

  // frame record survives select rise so the core can judge it afterwards
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      sh_r <= '0;
      cmdL_r <= CMD_NONE;
      addrL_r <= '0;
      mask_r <= '0;
      wrPtr_r <= '0;
      gotByte_r <= 1'b0;
      bitsL_r <= '0;
      stByte_r <= '0;
      txSh_r <= '0;
    end else if (holdN && !csN) begin
      // a stray sck edge while deselected must not wipe the record before the core judges it
      sh_r <= shNext;
      bitsL_r <= bitsL_r + 3'h1;
      case (phase_r)
        PH_OPC: begin
          if (cnt_r == '0) begin
            cmdL_r <= CMD_NONE;
            gotByte_r <= 1'b0;
          end
          if (cnt_r == OPC_LAST && opcPhase(shNext, busyL) != PH_IGN) begin
            cmdL_r <= shNext;
            if (shNext == CMD_READ_STATUS) begin
              txSh_r <= LEGACY_BUSY_ALL_ONES && busyL ? ST_ALL_ONES : stL2_r;
            end else begin
              mask_r <= '0;
            end
          end
        end
        PH_ADDR: begin
          addrL_r <= addrNext;
          if (cnt_r == ADDR_LAST) begin
            wrPtr_r <= addrNext[PAGE_W-1:0];
            txSh_r <= mem[addrNext];
          end
        end
        PH_DATA: begin
          if (bitsL_r == 3'h7) begin
            gotByte_r <= 1'b1;
            stByte_r <= shNext;
            if (cmdL_r == CMD_WRITE) begin
              mask_r[wrPtr_r] <= 1'b1;
              wrPtr_r <= wrPtr_r + 5'h01;
            end
          end
        end
        PH_SEND: begin
          if (sendCnt_r == 3'h7) begin
            if (cmdL_r == CMD_READ) begin
              addrL_r <= addrL_r + 10'h001;
              txSh_r <= mem[addrL_r + 10'h001];
            end else begin
              txSh_r <= LEGACY_BUSY_ALL_ONES && busyL ? ST_ALL_ONES : stL2_r;
            end
          end
        end
        default: ;
      endcase
      if (phase_r == PH_OPC && cnt_r == '0) begin
        bitsL_r <= 3'h1;
      end
    end
  end

  always_ff @(posedge sck) begin
    if (bufWe) begin
      pageBuf[wrPtr_r] <= shNext;
    end
  end

  // output changes on the falling edge so the host samples a settled bit
  always_ff @(negedge sck or negedge frameRstN) begin
    if (!frameRstN) begin
      so <= 1'b0;
      soOeN <= 1'b1;
    end else begin
      soOeN <= ~(phase_r == PH_SEND && holdN);
      so <= txSh_r[~sendCnt_r];
    end
  end

  // core side
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      csPrev <= 1'b1;
      wpS1 <= 1'b1;
      wpS2 <= 1'b1;
      wpPrev <= 1'b1;
    end else if (ce) begin
      csS1 <= csN;
      csS2 <= csS1;
      csPrev <= csS2;
      wpS1 <= wpN;
      wpS2 <= wpS1;
      wpPrev <= wpS2;
    end
  end

  assign csRise = ce && csS2 && !csPrev;
  assign csFall = ce && !csS2 && csPrev;
  assign wpFall = ce && wpPrev && !wpS2;
  assign cpLow = cpIdx_r[PAGE_W-1:0];

  always_comb begin
    framed = csRise && awake_r && !busy_r && bitsL_r == 3'h0;
    okWren = framed && cmdL_r == CMD_WRITE_ENABLE && !gotByte_r;
    okWrdi = framed && cmdL_r == CMD_WRITE_DISABLE && !gotByte_r;
    okWrite = framed && cmdL_r == CMD_WRITE && gotByte_r && wel_r && !isProt(bp_r, addrL_r);
    wpBlock = ppe_r && (!wpS2 || wpFell_r);
    okWrsr = framed && cmdL_r == CMD_WRITE_STATUS && gotByte_r && wel_r && !wpBlock;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awake_r <= 1'b0;
      wpFell_r <= 1'b0;
    end else if (ce) begin
      if (csFall) begin
        awake_r <= 1'b1;
      end
      if (!csS2 && wpFall) begin
        wpFell_r <= 1'b1;
      end else if (csFall) begin
        wpFell_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wel_r <= 1'b0;
      ppe_r <= 1'b0;
      bp_r <= 2'b00;
      busy_r <= 1'b0;
      isSt_r <= 1'b0;
      wcCnt_r <= '0;
      cpIdx_r <= '0;
      page_r <= '0;
      stNew_r <= '0;
    end else if (ce) begin
      if (okWren) begin
        wel_r <= 1'b1;
      end else if (okWrdi) begin
        wel_r <= 1'b0;
      end
      if (okWrite || okWrsr) begin
        busy_r <= 1'b1;
        wcCnt_r <= WC_W'(WC_CYCLES - 1);
        cpIdx_r <= '0;
        isSt_r <= okWrsr;
        stNew_r <= stByte_r;
        page_r <= addrL_r[ADDR_W-1:PAGE_W];
      end else if (busy_r) begin
        if (cpIdx_r != PAGE_BYTES) begin
          cpIdx_r <= cpIdx_r + 6'h01;
        end
        if (wcCnt_r == '0) begin
          busy_r <= 1'b0;
          wel_r <= 1'b0;
          if (isSt_r) begin
            ppe_r <= stNew_r[7];
            bp_r <= stNew_r[3:2];
          end
        end else begin
          wcCnt_r <= wcCnt_r - WC_W'(1);
        end
      end
    end
  end

  // page buffer is frozen while busy because the link refuses new writes then
  always_ff @(posedge clk) begin
    if (ce && busy_r && !isSt_r && !cpIdx_r[PAGE_W] && mask_r[cpLow]) begin
      mem[{page_r, cpLow}] <= pageBuf[cpLow];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      statusOut <= '0;
    end else if (ce) begin
      statusOut.protectPinEnable <= ppe_r;
      statusOut.zero <= 3'h0;
      statusOut.blockProtectHigh <= bp_r[1];
      statusOut.blockProtectLow <= bp_r[0];
      statusOut.writeEnableLatch <= wel_r;
      statusOut.rdy <= busy_r;
    end
  end

  a_cmd_write_enable_sets: assert property (@(posedge clk) disable iff (!rstn)
    okWren |=> wel_r) else $error("write enable did not set latch");
  a_cmd_write_disable_clears: assert property (@(posedge clk) disable iff (!rstn)
    okWrdi |=> !wel_r) else $error("write disable did not clear latch");
  a_no_wel_refuse: assert property (@(posedge clk) disable iff (!rstn)
    (csRise && !wel_r && !busy_r) |=> !busy_r) else $error("write taken without latch");
  a_protect_range: assert property (@(posedge clk) disable iff (!rstn)
    (csRise && !busy_r && cmdL_r == CMD_WRITE && isProt(bp_r, addrL_r)) |=> !busy_r)
    else $error("write into protected range started");
  a_wp_blocks: assert property (@(posedge clk) disable iff (!rstn)
    (csRise && !busy_r && cmdL_r == CMD_WRITE_STATUS && ppe_r && !wpS2) |=> !busy_r)
    else $error("status write passed protect pin");
  a_wp_abort: assert property (@(posedge clk) disable iff (!rstn)
    (csRise && !busy_r && cmdL_r == CMD_WRITE_STATUS && ppe_r && wpFell_r) |=> !busy_r)
    else $error("status write survived protect pin fall");
  a_start_at_rise: assert property (@(posedge clk) disable iff (!rstn)
    $rose(busy_r) |-> $past(csRise)) else $error("write cycle started without select rise");
  a_busy_length: assert property (@(posedge clk) disable iff (!rstn)
    (busy_r && ce && wcCnt_r != '0) |=> busy_r) else $error("write cycle ended early");
  a_wel_auto: assert property (@(posedge clk) disable iff (!rstn)
    $fell(busy_r) |-> !wel_r ##2 !statusOut.writeEnableLatch)
    else $error("latch not cleared after write cycle");
  a_busy_ignore: assert property (@(posedge clk) disable iff (!rstn)
    (busy_r && wcCnt_r > WC_W'(2)) |=> $stable(wel_r) && $stable(bp_r))
    else $error("state changed during write cycle");
  a_ready_flag: assert property (@(posedge clk) disable iff (!rstn)
    (ce && $past(ce)) |-> statusOut.rdy == $past(busy_r)) else $error("ready flag wrong");
  a_zero_bits: assert property (@(posedge clk) disable iff (!rstn)
    statusOut.zero == 3'h0) else $error("status bits 6 to 4 not zero");
  a_standby: assert property (@(posedge clk) disable iff (!rstn)
    !awake_r |-> !wel_r && !busy_r) else $error("active before first select");
endmodule

/* dv/spi_host_model.sv */
// spi host model that drives the serial link in mode 0 or mode 3
`timescale 1ns/100ps
module spi_host_model (
  output logic sck,
  output logic csN,
  output logic si,
  output logic holdN,
  input wire logic so,
  input wire logic soOeN
);
  // idle sck level: 0 selects mode 0, 1 mode 3; hold is only exercised in mode 0
  logic cpol;

  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    holdN = 1'b1;
    cpol = 1'b0;
  end

  // sck rests at cpol outside frames; si has no pull, so it toggles once released
  task automatic frame(input logic [7:0] txq[$], input int holdAt,
    output logic [7:0] rxq[$], output logic quiet, output logic heldOff);
    logic [7:0] b;
    quiet = 1'b1;
    heldOff = 1'b1;
    rxq = {};
    sck = cpol;
    #50 csN = 1'b0;
    #100;
    foreach (txq[k]) begin
      for (int i = 7; i >= 0; i--) begin
        if (k * 8 + 7 - i == holdAt) begin
          #20 holdN = 1'b0;
          repeat (2) begin
            si = ~si;
            #42.5 sck = 1'b1;
            #62.5 sck = 1'b0;
          end
          #20 heldOff = soOeN;
          holdN = 1'b1;
        end
        if (cpol) sck = 1'b0;
        si = txq[k][i];
        #62.5 sck = 1'b1;
        b[i] = so;
        quiet = quiet & soOeN;
        #62.5;
        if (!cpol) sck = 1'b0;
      end
      rxq.push_back(b);
    end
    #100 csN = 1'b1;
    si = ~si;
    #300;
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the spi eeprom core
`timescale 1ns/100ps
module testbench;
  import eeprom_pkg::*;
  localparam int WC = 400;
  localparam logic [9:0] ADDRS [4] = '{10'h000, 10'h1E0, 10'h2E0, 10'h300};
  logic clk;
  logic rstn;
  logic ce;
  logic wpN;
  wire sck;
  wire csN;
  wire si;
  wire holdN;
  logic so;
  logic soOeN;
  status_s statusOut;
  int miscompares;
  int n_tests;
  logic [7:0] st;
  logic [7:0] mem [int];
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  logic quiet;
  logic heldOff;

  spi_eeprom_core #(.WC_CYCLES(WC), .LEGACY_BUSY_ALL_ONES(1'b0)) dut (.clk(clk), .rstn(rstn),
    .ce(ce), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .wpN(wpN), .so(so),
    .soOeN(soOeN), .statusOut(statusOut));
  spi_host_model host (.sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so),
    .soOeN(soOeN));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic int thr();
    return st[3:2] == 2'b00 ? 1024 : st[3:2] == 2'b01 ? 768 : st[3:2] == 2'b10 ? 512 : 0;
  endfunction

  task automatic run(input logic [7:0] q[$]);
    host.frame(q, -1, rx, quiet, heldOff);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] stNew);
    run({op});
    st = stNew;
    check("status after command", statusOut, st);
  endtask

  task automatic cmd_write_enable();
    cmd(CMD_WRITE_ENABLE, st | 8'h02);
  endtask

  // the write cycle must outlast a status read plus a disable frame
  task automatic busyPhase(input logic [7:0] stNew);
    check("busy flag", statusOut, st | 8'h01);
    run({CMD_READ_STATUS, 8'h00});
    check("status while busy", rx[1], st | 8'h01);
    run({CMD_WRITE_DISABLE});
    check("disable while busy", statusOut, st | 8'h01);
    st = stNew;
    for (int k = 0; k < 30; k++) begin
      run({CMD_READ_STATUS, 8'h00});
      if (rx[1][ST_RDY] === 1'b0) break;
    end
    check("status after cycle", rx[1], st);
  endtask

  task automatic wr(input logic [9:0] a, input int n);
    logic [15:0] fa;
    bit ok;
    fa = {6'($urandom), a};
    ok = st[1] && int'(a) < thr();
    tx = {CMD_WRITE, fa[15:8], fa[7:0]};
    for (int i = 0; i < n; i++) begin
      tx.push_back(8'($urandom));
      if (ok) mem[int'({a[9:5], 5'(a[4:0] + i)})] = tx[$];
    end
    run(tx);
    if (ok) busyPhase(st & 8'hFD);
    else check("refused write", statusOut, st);
  endtask

  task automatic cmd_write_status(input logic [7:0] v, input bit fall);
    bit ok;
    tx = {CMD_WRITE_STATUS, v};
    if (fall) fork
      run(tx);
      begin
        // the pin falls and recovers inside the frame, so only the abort can refuse it
        #600;
        @(negedge clk) wpN = 1'b0;
        #600;
        @(negedge clk) wpN = 1'b1;
      end
    join
    else run(tx);
    ok = st[1] && !(st[7] && (wpN === 1'b0 || fall));
    if (ok) busyPhase(v & 8'h8C);
    else check("refused status write", statusOut, st);
  endtask

  task automatic rd(input logic [9:0] a, input int n, input int holdAt);
    logic [15:0] fa;
    fa = {6'($urandom), a};
    tx = {CMD_READ, fa[15:8], fa[7:0]};
    repeat (n) tx.push_back(8'($urandom));
    host.frame(tx, holdAt, rx, quiet, heldOff);
    for (int i = 0; i < n; i++) begin
      check("read data", rx[3 + i], mem[(int'(a) + i) % 1024]);
    end
    check("released in hold", {7'h00, heldOff}, 8'h01);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #1500000;
    miscompares++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hBAA2D320));
    miscompares = 0;
    n_tests = 0;
    rstn = 1'b0;
    ce = 1'b1;
    wpN = 1'b1;
    st = 8'h00;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check("reset status", statusOut, 8'h00);
    wr(10'h000, 1);
    cmd_write_enable();
    cmd(CMD_WRITE_DISABLE, st & 8'hFD);
    cmd_write_status(8'h8C, 1'b0);
    run({8'h80 | 8'($urandom), 8'h00});
    check("unknown opcode output", {7'h00, quiet}, 8'h01);
    check("unknown opcode status", statusOut, st);
    cmd_write_enable();
    wr(10'h3E0, 34);
    rd(10'h3E0, 32, 30);
    for (int bp = 3; bp >= 0; bp--) begin
      cmd_write_enable();
      cmd_write_status(8'(bp << 2) | (8'($urandom) & 8'h73), 1'b0);
      foreach (ADDRS[j]) begin
        cmd_write_enable();
        wr(ADDRS[j], 2);
      end
    end
    // from here on the link runs in mode 3
    @(negedge clk) host.cpol = 1'b1;
    rd(10'h3FE, 4, -1);
    cmd_write_enable();
    cmd_write_status(8'h80, 1'b0);
    @(negedge clk) wpN = 1'b0;
    cmd_write_enable();
    cmd_write_status(8'h8C, 1'b0);
    @(negedge clk) wpN = 1'b1;
    cmd_write_status(8'h8C, 1'b1);
    @(negedge clk) wpN = 1'b1;
    cmd_write_status(8'h04, 1'b0);
    @(negedge clk) wpN = 1'b0;
    cmd_write_enable();
    cmd_write_status(8'h08, 1'b0);
    complete_run();
  end
endmodule

/* pkg/eeprom_pkg.sv */
// package: constants and types for the spi eeprom core
package eeprom_pkg;
  localparam int ADDR_W = 10;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int CNT_W = 5;
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h0F;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [ADDR_W:0] PROT_NONE = 11'h400;
  localparam logic [ADDR_W:0] PROT_QTR = 11'h300;
  localparam logic [ADDR_W:0] PROT_HALF = 11'h200;
  localparam logic [ADDR_W:0] PROT_ALL = 11'h000;
  localparam int ST_RDY = 0;
  localparam logic [7:0] ST_ALL_ONES = 8'hFF;
  localparam int WC_TIME_MS = 5;
  localparam int CLK_MHZ = 50;
  localparam int WC_CYCLES = WC_TIME_MS * 1000 * CLK_MHZ;
  localparam int WC_W = 18;

  typedef enum logic [4:0] {
    PH_OPC = 5'b00001,
    PH_ADDR = 5'b00010,
    PH_DATA = 5'b00100,
    PH_SEND = 5'b01000,
    PH_IGN = 5'b10000
  } phase_e;

  typedef struct packed {
    logic protectPinEnable;
    logic [2:0] zero;
    logic blockProtectHigh;
    logic blockProtectLow;
    logic writeEnableLatch;
    logic rdy;
  } status_s;
endpackage
